// File: verilog/ebsi_consts.svh
// Constants of the expansion bus status and interrupt block
`ifndef EBSI_CONSTS_SVH
`define EBSI_CONSTS_SVH

// Status triple {memory/io select, direction, low status}
`define EBSI_ST_FETCH 3'h0
`define EBSI_ST_MEM_RD 3'h1
`define EBSI_ST_MEM_WR 3'h2
`define EBSI_ST_PASSIVE 3'h3
`define EBSI_ST_IRQ_ACK 3'h4
`define EBSI_ST_IO_RD 3'h5
`define EBSI_ST_IO_WR 3'h6
`define EBSI_ST_HALT 3'h7

// Interrupt vector type raised by the non-maskable input
`define EBSI_NMI_TYPE 8'h02

// Interrupt controller level positions
`define EBSI_LVL_SYNC 0
`define EBSI_LVL_SERIAL 1
`define EBSI_LVL_TIMER 2
`define EBSI_LVL_SHARED 3
`define EBSI_LVL_EXP_A 4
`define EBSI_LVL_EXP_B 5
`define EBSI_LVL_KEYBOARD 6
`define EBSI_LVL_VERTICAL 7

// Synchroniser lanes of the pin inputs
`define EBSI_SYN_WIDTH 16
`define EBSI_SYN_HOLD 15
`define EBSI_SYN_EXTERNAL_ACKNOWLEDGE_N 14
`define EBSI_SYN_NMI_N 13
`define EBSI_SYN_SHARED_N 12
`define EBSI_SYN_EXP_A 11
`define EBSI_SYN_EXP_B 10
`define EBSI_SYN_POWER_ON 9
`define EBSI_SYN_MANUAL_N 8
// Idle levels: active-low lines high, all else low
`define EBSI_SYN_RESET_VAL 16'h7100

`endif

// File: verilog/ebsi_pkg.sv
// Types of the expansion bus status and interrupt block
`default_nettype none
package ebsi_pkg;

  typedef enum logic [1:0] {
    ST_OWNED,
    ST_DRAIN,
    ST_GRANTED,
    ST_RECLAIM
  } ebsi_hold_state_t;

  typedef enum logic [2:0] {
    CK_FETCH,
    CK_MEM_RD,
    CK_MEM_WR,
    CK_PASSIVE,
    CK_IRQ_ACK,
    CK_IO_RD,
    CK_IO_WR,
    CK_HALT
  } ebsi_cycle_kind_t;

endpackage : ebsi_pkg
`default_nettype wire

// File: verilog/ebsi_irq_if.sv
// Interrupt signals passed between the bus front and the level map
`default_nettype none
interface ebsi_irq_if;
  logic nmiN;
  logic sharedN;
  logic expA;
  logic expB;
  logic syncDetect;
  logic serialReq;
  logic timerReq;
  logic keyboardLevel;
  logic verticalLevel;
  logic nmiTake;
  logic nmiPending;
  logic [7:0] levels;

  modport front (
    output nmiN, sharedN, expA, expB, syncDetect, serialReq, timerReq,
    output keyboardLevel, verticalLevel, nmiTake,
    input nmiPending, levels
  );
  modport map (
    input nmiN, sharedN, expA, expB, syncDetect, serialReq, timerReq,
    input keyboardLevel, verticalLevel, nmiTake,
    output nmiPending, levels
  );
endinterface : ebsi_irq_if
`default_nettype wire

// File: verilog/ebsi_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none
module ebsi_sync #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ebsi_sync_state_t;

  ebsi_sync_state_t st_q;
  ebsi_sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = asyncIn;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= {RESET_VAL, RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.s2;

  chk_sync_two_stage: assert property (@(posedge clock) disable iff (rst)
    !$past(rst, 2) && !$past(rst) |-> syncOut == $past(asyncIn, 2))
    else $error("synchroniser delay is not two cycles");

endmodule : ebsi_sync
`default_nettype wire

// File: verilog/ebsi_irq_map.sv
// Non-maskable edge catch and interrupt controller level map
`default_nettype none
`include "ebsi_consts.svh"
module ebsi_irq_map (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Interrupt group
  ebsi_irq_if.map irq
);

  typedef struct packed {
    logic nmiPrev;
    logic nmiPending;
    logic [7:0] levels;
  } ebsi_map_state_t;

  ebsi_map_state_t st_q;
  ebsi_map_state_t st_d;
  logic nmiFall;

  always_comb begin
    st_d = st_q;
    st_d.nmiPrev = irq.nmiN;
    // Falling edge only; a held low level raises nothing more
    nmiFall = st_q.nmiPrev && !irq.nmiN;
    // A new edge in the cycle of acceptance stays pending
    st_d.nmiPending = nmiFall || (st_q.nmiPending && !irq.nmiTake);
    st_d.levels[`EBSI_LVL_SYNC] = irq.syncDetect;
    st_d.levels[`EBSI_LVL_SERIAL] = irq.serialReq;
    st_d.levels[`EBSI_LVL_TIMER] = irq.timerReq;
    st_d.levels[`EBSI_LVL_SHARED] = !irq.sharedN;
    st_d.levels[`EBSI_LVL_EXP_A] = irq.expA;
    st_d.levels[`EBSI_LVL_EXP_B] = irq.expB;
    st_d.levels[`EBSI_LVL_KEYBOARD] = irq.keyboardLevel;
    st_d.levels[`EBSI_LVL_VERTICAL] = irq.verticalLevel;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '{nmiPrev: 1'b1, nmiPending: 1'b0, levels: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign irq.nmiPending = st_q.nmiPending;
  assign irq.levels = st_q.levels;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_nmi_edge_sets: assert property (
    $fell(irq.nmiN) |=> irq.nmiPending)
    else $error("falling nmi edge not made pending");
  chk_nmi_level_quiet: assert property (
    !irq.nmiPending && !irq.nmiN && $past(!irq.nmiN) |=> !irq.nmiPending)
    else $error("held low nmi raised a request");
  chk_shared_low_high: assert property (
    irq.sharedN == 1'b0 |=> irq.levels[`EBSI_LVL_SHARED])
    else $error("shared low did not raise level three");
  chk_direct_levels: assert property (
    ##1 irq.levels[5:4] == $past({irq.expB, irq.expA}))
    else $error("direct levels not passed straight");
  chk_level_map: assert property (
    ##1 {irq.levels[7:6], irq.levels[2:0]} == $past({irq.verticalLevel,
      irq.keyboardLevel, irq.timerReq, irq.serialReq, irq.syncDetect}))
    else $error("interrupt level map wrong");

endmodule : ebsi_irq_map
`default_nettype wire

// File: verilog/ebsi_bus_front.sv
// Expansion bus front: hold grant, ready, cycle status, reset and interrupts
// Operation
// - While hold grant is high all buffered bus and strobe outputs are floated.
// - The ready status pin shows the synchronized ready actually applied to the processor.
// - The memory/io select pin tells whether the cycle addresses memory or I/O.
// - The direction pin steers the transceivers for the current transfer.
// - With select low the triple means fetch, memory read, memory write, passive.
// - With select high the triple means irq acknowledge, I/O read, I/O write, halt.
// - A falling edge on the non-maskable input raises a type-2 interrupt at instruction end.
// - A low shared request line appears as a high request at level three.
// - The two direct expansion inputs go straight to levels four and five.
// - The bus reset output is driven at power-on and on the manual reset input.
// - Levels map sync, serial, timer, shared, expansion a, b, keyboard, vertical.
`default_nettype none
`include "ebsi_consts.svh"
module ebsi_bus_front (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor bus side
  input wire logic [11:0] cpuAddr,
  input wire logic [7:0] cpuAdOut,
  input wire logic cpuAdOe,
  input wire logic cpuAle,
  input wire logic cpuIoSel,
  input wire logic cpuRd,
  input wire logic cpuWr,
  input wire logic cpuDir,
  input wire logic cpuXcvrEn,
  input wire logic cpuLowStatus,
  input wire logic cpuIrqAck,
  input wire logic cpuDataStrobe,
  input wire logic cpuReadyIn,
  input wire logic cpuInstrEnd,
  output logic [7:0] cpuAdIn,
  output logic cpuReady,
  output logic cpuHoldStall,
  output logic cpuNmiPending,
  output logic [7:0] cpuNmiType,
  output logic [7:0] irqLevels,
  output ebsi_pkg::ebsi_cycle_kind_t cycleKind,
  // On-board interrupt sources
  input wire logic syncDetect,
  input wire logic serialReq,
  input wire logic timerReq,
  input wire logic keyboardLevel,
  input wire logic verticalLevel,
  // Expansion bus address and data pins
  output logic [11:0] busAddr,
  output logic busAddrOe,
  input wire logic [7:0] busAdIn,
  output logic [7:0] busAdOut,
  output logic busAdOe,
  // Expansion bus control pins, busCtlOe for the group, own enable for the read data strobe
  output logic busAle,
  output logic busIoSel,
  output logic busRd,
  output logic busWr,
  output logic busDir,
  output logic busXcvrEn,
  output logic busLowStatus,
  output logic busIrqAck,
  output logic busCtlOe,
  output logic readDataStrobe,
  output logic readDataStrobeOe,
  // Expansion bus status and request pins
  output logic holdGrant,
  output logic readyStatus,
  output logic busReset,
  input wire logic holdReq,
  input wire logic externalAckN,
  input wire logic nmiN,
  input wire logic sharedIrqN,
  input wire logic expansionLevelA,
  input wire logic expansionLevelB,
  input wire logic powerOn,
  input wire logic manualResetN
);

  typedef struct packed {
    ebsi_pkg::ebsi_hold_state_t hold;
    logic grant;
    logic ready;
    ebsi_pkg::ebsi_cycle_kind_t kind;
    logic busReset;
    logic [11:0] addr;
    logic [7:0] adOut;
    logic adOe;
    logic ale;
    logic ioSel;
    logic rd;
    logic wr;
    logic dir;
    logic xcvrEn;
    logic lowStatus;
    logic irqAck;
    logic dataStrobe;
  } ebsi_front_state_t;

  ebsi_front_state_t st_q;
  ebsi_front_state_t st_d;

  logic [`EBSI_SYN_WIDTH-1:0] synIn;
  logic [`EBSI_SYN_WIDTH-1:0] synOut;
  logic holdSync;
  logic xackSync;
  logic powerOnSync;
  logic manualSync;
  logic [2:0] cpuTriple;
  logic cpuIdle;

  ebsi_irq_if irq ();

  // Pin inputs reach logic only through two flip-flops
  assign synIn = {holdReq, externalAckN, nmiN, sharedIrqN, expansionLevelA,
                  expansionLevelB, powerOn, manualResetN, busAdIn};

  ebsi_sync #(
    .WIDTH(`EBSI_SYN_WIDTH),
    .RESET_VAL(`EBSI_SYN_RESET_VAL)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn(synIn),
    .syncOut(synOut)
  );

  assign holdSync = synOut[`EBSI_SYN_HOLD];
  assign xackSync = synOut[`EBSI_SYN_EXTERNAL_ACKNOWLEDGE_N];
  assign powerOnSync = synOut[`EBSI_SYN_POWER_ON];
  assign manualSync = !synOut[`EBSI_SYN_MANUAL_N];
  assign cpuAdIn = synOut[7:0];

  assign irq.nmiN = synOut[`EBSI_SYN_NMI_N];
  assign irq.sharedN = synOut[`EBSI_SYN_SHARED_N];
  assign irq.expA = synOut[`EBSI_SYN_EXP_A];
  assign irq.expB = synOut[`EBSI_SYN_EXP_B];
  assign irq.syncDetect = syncDetect;
  assign irq.serialReq = serialReq;
  assign irq.timerReq = timerReq;
  assign irq.keyboardLevel = keyboardLevel;
  assign irq.verticalLevel = verticalLevel;
  assign irq.nmiTake = cpuInstrEnd && irq.nmiPending;

  ebsi_irq_map u_map (
    .clock(clock),
    .rst(rst),
    .irq(irq.map)
  );

  assign cpuTriple = {cpuIoSel, cpuDir, cpuLowStatus};
  // Bus is free for a hand-over only between cycles
  assign cpuIdle = (cpuTriple == `EBSI_ST_PASSIVE) && !cpuAle;

  always_comb begin
    st_d = st_q;
    // Hand-over of the buses to an external master
    case (st_q.hold)
      ebsi_pkg::ST_OWNED: begin
        if (holdSync) begin
          st_d.hold = ebsi_pkg::ST_DRAIN;
        end
      end
      ebsi_pkg::ST_DRAIN: begin
        if (!holdSync) begin
          st_d.hold = ebsi_pkg::ST_OWNED;
        end else if (cpuIdle) begin
          st_d.hold = ebsi_pkg::ST_GRANTED;
          st_d.grant = 1'b1;
        end
      end
      ebsi_pkg::ST_GRANTED: begin
        if (!holdSync) begin
          st_d.hold = ebsi_pkg::ST_RECLAIM;
          st_d.grant = 1'b0;
        end
      end
      ebsi_pkg::ST_RECLAIM: begin
        st_d.hold = ebsi_pkg::ST_OWNED;
      end
      default: begin
        st_d.hold = ebsi_pkg::ST_OWNED;
        st_d.grant = 1'b0;
      end
    endcase
    // Ready applied to the processor includes external wait states
    st_d.ready = cpuReadyIn && xackSync;
    // Cycle status decode of the triple
    case (cpuTriple)
      `EBSI_ST_FETCH: st_d.kind = ebsi_pkg::CK_FETCH;
      `EBSI_ST_MEM_RD: st_d.kind = ebsi_pkg::CK_MEM_RD;
      `EBSI_ST_MEM_WR: st_d.kind = ebsi_pkg::CK_MEM_WR;
      `EBSI_ST_PASSIVE: st_d.kind = ebsi_pkg::CK_PASSIVE;
      `EBSI_ST_IRQ_ACK: st_d.kind = ebsi_pkg::CK_IRQ_ACK;
      `EBSI_ST_IO_RD: st_d.kind = ebsi_pkg::CK_IO_RD;
      `EBSI_ST_IO_WR: st_d.kind = ebsi_pkg::CK_IO_WR;
      `EBSI_ST_HALT: st_d.kind = ebsi_pkg::CK_HALT;
      default: st_d.kind = ebsi_pkg::CK_PASSIVE;
    endcase
    st_d.busReset = powerOnSync || manualSync;
    // Buffered copies of the processor bus
    st_d.addr = cpuAddr;
    st_d.adOut = cpuAdOut;
    st_d.adOe = cpuAdOe;
    st_d.ale = cpuAle;
    st_d.ioSel = cpuIoSel;
    st_d.rd = cpuRd;
    st_d.wr = cpuWr;
    st_d.dir = cpuDir;
    st_d.xcvrEn = cpuXcvrEn;
    st_d.lowStatus = cpuLowStatus;
    st_d.irqAck = cpuIrqAck;
    st_d.dataStrobe = cpuDataStrobe;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '{
        hold: ebsi_pkg::ST_OWNED,
        grant: 1'b0,
        ready: 1'b0,
        kind: ebsi_pkg::CK_PASSIVE,
        busReset: 1'b1,
        addr: 12'h000,
        adOut: 8'h00,
        adOe: 1'b0,
        ale: 1'b0,
        ioSel: 1'b0,
        rd: 1'b0,
        wr: 1'b0,
        dir: 1'b1,
        xcvrEn: 1'b0,
        lowStatus: 1'b1,
        irqAck: 1'b0,
        dataStrobe: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Floated group follows the grant register itself
  assign busAddrOe = !st_q.grant;
  assign busAdOe = !st_q.grant && st_q.adOe;
  assign busCtlOe = !st_q.grant;
  // External master owns the read data strobe while granted
  assign readDataStrobeOe = !st_q.grant;

  assign busAddr = st_q.addr;
  assign busAdOut = st_q.adOut;
  assign busAle = st_q.ale;
  assign busIoSel = st_q.ioSel;
  assign busRd = st_q.rd;
  assign busWr = st_q.wr;
  assign busDir = st_q.dir;
  assign busXcvrEn = st_q.xcvrEn;
  assign busLowStatus = st_q.lowStatus;
  assign busIrqAck = st_q.irqAck;
  assign readDataStrobe = st_q.dataStrobe;

  assign holdGrant = st_q.grant;
  assign readyStatus = st_q.ready;
  assign cpuReady = st_q.ready;
  // No new processor cycle while hold is requested, the bus is away or being retaken
  assign cpuHoldStall = (st_q.hold != ebsi_pkg::ST_OWNED);
  assign cycleKind = st_q.kind;
  assign busReset = st_q.busReset;
  assign cpuNmiPending = irq.nmiPending;
  assign cpuNmiType = `EBSI_NMI_TYPE;
  assign irqLevels = irq.levels;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_float_on_grant: assert property (
    holdGrant |-> !busAddrOe && !busAdOe && !busCtlOe)
    else $error("bus driven while hold granted");
  chk_ready_wait: assert property (
    !xackSync |=> !readyStatus && !cpuReady)
    else $error("external acknowledge wait not shown on ready");
  chk_ready_follow: assert property (
    cpuReadyIn && xackSync |=> readyStatus)
    else $error("ready status did not follow applied ready");
  chk_iosel_copy: assert property (
    ##1 busIoSel == $past(cpuIoSel))
    else $error("memory io select not passed");
  chk_dir_copy: assert property (
    ##1 busDir == $past(cpuDir))
    else $error("transfer direction not passed");
  chk_status_mem: assert property (
    cpuTriple == `EBSI_ST_MEM_WR |=> cycleKind == ebsi_pkg::CK_MEM_WR)
    else $error("memory write status decoded wrong");
  chk_status_io: assert property (
    cpuTriple == `EBSI_ST_IO_RD |=> cycleKind == ebsi_pkg::CK_IO_RD)
    else $error("io read status decoded wrong");
  chk_grant_stays: assert property (
    holdGrant && holdSync |=> holdGrant)
    else $error("grant dropped while hold still requested");
  chk_grant_release: assert property (
    holdGrant && !holdSync |=> !holdGrant ##1 !cpuHoldStall)
    else $error("grant not released in time");
  chk_reset_manual: assert property (
    manualSync |=> busReset)
    else $error("manual reset did not drive bus reset");

endmodule : ebsi_bus_front
`default_nettype wire

// File: bench/ebsi_board_model.sv
// Expansion board model: external bus master, acknowledge and interrupt sources
`default_nettype none
module ebsi_board_model (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic wantHold,
  input wire logic waitAck,
  input wire logic nmiLow,
  input wire logic irqLow,
  input wire logic levA,
  input wire logic levB,
  // Expansion bus pins
  input wire logic holdGrant,
  output logic holdReq = 1'b0,
  output logic externalAckN = 1'b1,
  output logic nmiN = 1'b1,
  output logic sharedLowEn = 1'b0,
  output logic expansionLevelA = 1'b0,
  output logic expansionLevelB = 1'b0,
  output logic strobeOut = 1'b1,
  output logic strobeOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobeEn = 1'b0;

  // Read strobe is ours only while the grant stands
  assign strobeOe = strobeEn & holdGrant;

  always @(posedge clock) begin
    // Request stays up through the grant until the bench lets go
    holdReq <= wantHold;
    externalAckN <= ~waitAck;
    nmiN <= ~nmiLow;
    // Open-collector: only ever pulls low, never drives high
    sharedLowEn <= irqLow;
    expansionLevelA <= levA;
    expansionLevelB <= levB;
    strobeEn <= holdGrant;
    strobeOut <= holdGrant ? ~strobeOut : 1'b1;
  end
endmodule : ebsi_board_model
`default_nettype wire

// File: bench/expansion_bus_status_and_irq_tb.sv
// Self-checking bench for the expansion bus front
`default_nettype none
module expansion_bus_status_and_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [11:0] cpuAddr = '0;
  logic [7:0] cpuAdOut = '0, boardData = '0;
  logic cpuAdOe = 1'b0, cpuAle = 1'b0, cpuIoSel = 1'b0, cpuRd = 1'b0, cpuWr = 1'b0;
  logic cpuDir = 1'b1, cpuXcvrEn = 1'b0, cpuLowStatus = 1'b1, cpuIrqAck = 1'b0;
  logic cpuDataStrobe = 1'b0, cpuReadyIn = 1'b0, cpuInstrEnd = 1'b0;
  logic syncDetect = 1'b0, serialReq = 1'b0, timerReq = 1'b0, keyboardLevel = 1'b0;
  logic verticalLevel = 1'b0, powerOn = 1'b0, manualResetN = 1'b1;
  logic wantHold = 1'b0, waitAck = 1'b0, nmiLow = 1'b0, irqLow = 1'b0, tbIrqLow = 1'b0;
  logic levA = 1'b0, levB = 1'b0;
  wire logic holdReq, externalAckN, nmiN, sharedLowEn, expansionLevelA, expansionLevelB;
  wire logic strobeOut, strobeOe, sharedIrqN;
  wire logic [7:0] busAdIn;
  logic [7:0] cpuAdIn, cpuNmiType, irqLevels, busAdOut;
  logic [11:0] busAddr;
  ebsi_pkg::ebsi_cycle_kind_t cycleKind;
  logic cpuReady, cpuHoldStall, cpuNmiPending, busAddrOe, busAdOe, busAle, busIoSel, busRd;
  logic busWr, busDir, busXcvrEn, busLowStatus, busIrqAck, busCtlOe, readDataStrobe;
  logic readDataStrobeOe, holdGrant, readyStatus, busReset;
  int nMismatch = 0;
  int checksDone = 0;
  int seed = 32'h0000_8651;

  // Pulled-up shared request line, two open-collector sources
  assign sharedIrqN = ~(sharedLowEn | tbIrqLow);
  assign busAdIn = busAdOe ? busAdOut : boardData;

  ebsi_board_model board_u (
    .clock, .wantHold, .waitAck, .nmiLow, .irqLow, .levA, .levB, .holdGrant,
    .holdReq, .externalAckN, .nmiN, .sharedLowEn, .expansionLevelA, .expansionLevelB,
    .strobeOut(), .strobeOe
  );

  ebsi_bus_front dut_u (
    .clock, .rst, .cpuAddr, .cpuAdOut, .cpuAdOe, .cpuAle, .cpuIoSel, .cpuRd, .cpuWr,
    .cpuDir, .cpuXcvrEn, .cpuLowStatus, .cpuIrqAck, .cpuDataStrobe, .cpuReadyIn,
    .cpuInstrEnd, .cpuAdIn, .cpuReady, .cpuHoldStall, .cpuNmiPending, .cpuNmiType,
    .irqLevels, .cycleKind, .syncDetect, .serialReq, .timerReq, .keyboardLevel,
    .verticalLevel, .busAddr, .busAddrOe, .busAdIn, .busAdOut, .busAdOe, .busAle,
    .busIoSel, .busRd, .busWr, .busDir, .busXcvrEn, .busLowStatus, .busIrqAck, .busCtlOe,
    .readDataStrobe, .readDataStrobeOe, .holdGrant, .readyStatus, .busReset, .holdReq,
    .externalAckN, .nmiN, .sharedIrqN, .expansionLevelA, .expansionLevelB, .powerOn,
    .manualResetN
  );

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finishTest

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic endTest(input string name);
    $display("test %s done", name);
  endtask : endTest

  task automatic waitGrant(input logic lvl);
    int i;
    for (i = 0; i < 40 && holdGrant !== lvl; i++) @(negedge clock);
    if (holdGrant !== lvl) begin
      nMismatch++;
      $display("[FAIL] grant wait timed out");
      finishTest();
    end
  endtask : waitGrant

  // Controller levels: sync, serial, timer, shared, exp a, exp b, keyboard, vertical
  function automatic logic [7:0] expLevels(input logic [8:0] s);
    return {s[7:4], s[3] | s[8], s[2:0]};
  endfunction : expLevels

  initial begin
    int i;
    logic [2:0] t;
    logic [5:0] c;
    logic [8:0] s;
    cyc(20);
    check("rstGrant", holdGrant, 1'b0);
    check("rstBusReset", busReset, 1'b1);
    check("rstLevels", irqLevels, 8'h00);
    check("rstKind", 16'(cycleKind), 16'(3'h3));
    rst = 1'b0;
    cyc(4);
    // Every status triple first, then random ones with random strobes
    for (i = 0; i < 16; i++) begin
      t = (i < 8) ? i[2:0] : 3'($random(seed));
      c = 6'($random(seed));
      {cpuIoSel, cpuDir, cpuLowStatus} = t;
      {cpuAle, cpuRd, cpuWr, cpuXcvrEn, cpuIrqAck, cpuDataStrobe} = c;
      cpuAddr = 12'($random(seed));
      cpuAdOut = 8'($random(seed));
      cpuAdOe = 1'b1;
      cyc(1);
      check("kind", 16'(cycleKind), 16'(t));
      check("ioSel", busIoSel, t[2]);
      check("dir", busDir, t[1]);
      check("lowStatus", busLowStatus, t[0]);
      check("strobes", {busAle, busRd, busWr, busXcvrEn, busIrqAck, readDataStrobe}, c);
      check("addr", busAddr, cpuAddr);
      check("adOut", busAdOut, cpuAdOut);
      check("driven", {busAddrOe, busAdOe, busCtlOe, readDataStrobeOe}, 4'hf);
    end
    endTest("status");
    for (i = 0; i < 4; i++) begin
      {cpuReadyIn, waitAck} = i[1:0];
      cyc(5);
      check("readyStatus", readyStatus, cpuReadyIn & ~waitAck);
      check("cpuReady", cpuReady, cpuReadyIn & ~waitAck);
    end
    endTest("ready");
    // Processor busy: request must wait
    {cpuIoSel, cpuDir, cpuLowStatus} = 3'h0;
    cpuAle = 1'b0;
    wantHold = 1'b1;
    cyc(10);
    check("grantBusy", holdGrant, 1'b0);
    check("stall", cpuHoldStall, 1'b1);
    {cpuIoSel, cpuDir, cpuLowStatus} = 3'h3;
    boardData = 8'($random(seed));
    waitGrant(1'b1);
    check("floated", {busAddrOe, busAdOe, busCtlOe, readDataStrobeOe}, 4'h0);
    cpuAle = 1'b1;
    cyc(8);
    check("grantHeld", holdGrant, 1'b1);
    check("stillFloat", {busAddrOe, busAdOe, busCtlOe, readDataStrobeOe}, 4'h0);
    check("strobeClash", readDataStrobeOe & strobeOe, 1'b0);
    check("boardStrobe", strobeOe, 1'b1);
    check("dataIn", cpuAdIn, boardData);
    cpuAle = 1'b0;
    wantHold = 1'b0;
    waitGrant(1'b0);
    check("retaken", {busAddrOe, busAdOe, busCtlOe, readDataStrobeOe}, 4'hf);
    cyc(2);
    check("stallOff", cpuHoldStall, 1'b0);
    endTest("hold");
    nmiLow = 1'b1;
    cyc(5);
    check("nmiRaise", cpuNmiPending, 1'b1);
    check("nmiType", cpuNmiType, 8'h02);
    cyc(3);
    check("nmiWait", cpuNmiPending, 1'b1);
    cpuInstrEnd = 1'b1;
    cyc(1);
    cpuInstrEnd = 1'b0;
    cyc(2);
    check("nmiTaken", cpuNmiPending, 1'b0);
    cyc(5);
    check("nmiLevel", cpuNmiPending, 1'b0);
    nmiLow = 1'b0;
    cyc(5);
    check("nmiRise", cpuNmiPending, 1'b0);
    endTest("nmi");
    for (i = 0; i < 12; i++) begin
      s = (i == 0) ? 9'h100 : (i == 1) ? 9'h008 : (i == 2) ? 9'h1ff : 9'($random(seed));
      {verticalLevel, keyboardLevel, levB, levA, irqLow} = s[7:3];
      {timerReq, serialReq, syncDetect} = s[2:0];
      tbIrqLow = s[8];
      cyc(5);
      check("levels", irqLevels, expLevels(s));
    end
    endTest("levels");
    manualResetN = 1'b0;
    cyc(5);
    check("switchReset", busReset, 1'b1);
    manualResetN = 1'b1;
    cyc(5);
    check("resetOff", busReset, 1'b0);
    powerOn = 1'b1;
    cyc(5);
    check("powerReset", busReset, 1'b1);
    powerOn = 1'b0;
    cyc(5);
    check("powerOff", busReset, 1'b0);
    endTest("busReset");
    finishTest();
  end
endmodule : expansion_bus_status_and_irq_tb
`default_nettype wire
